// ---- rtl/tcs_top.sv ----
// Behaviour
// [RQ1] transmit runs only while enabled and selected buffer done is clear
// [RQ2] enable rising from zero clears all transmit error flags
// [RQ3] enable cleared mid-message: error bit, active done, interrupt, no flags
// [RQ4] enable clears on reset, init, DMA error, underrun, length error
// [RQ5] buffer select 0 primary 1 secondary, toggles on DMA end
// [RQ6] between messages idle bit picks sync, mark or flag fill
// [RQ7] enable cleared after a good message may leave the line marking
// [RQ8] data set change with its enable raises a transmit interrupt
// [RQ9] done or error becoming set with enable raises transmit interrupt
// [RQ10] change bit sets on modem edges, clears on modem read or reset
// [RQ11] secondary done sets on message end, clears on count 13 write
// [RQ12] primary done sets on message end, clears on count 11 write
// [RQ13] clock source picks modem clock or internal baud generator
// [RQ14] invert bit flips receive clock unless internal loop is active
// [RQ15] error bit is OR of flags and abort, clears on error register read
// [RQ16] misc register at offset 8, word access, read-modify-write allowed
// [RQ17] 4-bit pointer selects indirect register, data writes increment it
// [RQ18] indirect data latched whenever pointer is written or changes
// [RQ19] pointer keeps its value through master reset and init
// [RQ20] master reset bit starts reset, self-clears, repeats ignored
// [RQ21] master reset marks line, disables receiver, keeps counts
// [RQ22] flag register latches modem transitions until modem read
// [RQ23] indirect 2 holds errors and baud rate, 10-13 buffers
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic        bus_sel_i,
  input  wire logic        bus_wr_i,
  input  wire logic [3:0]  bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [15:0] bus_rdata_o,
  output logic             bus_ack_o,
  // transmit engine events
  input  wire logic        tx_active_i,
  input  wire logic        tx_msg_done_i,
  input  wire logic        tx_dma_end_i,
  input  wire logic        tx_dma_err_i,
  input  wire logic        tx_underrun_i,
  input  wire logic        tx_len_err_i,
  input  wire logic        int_loop_i,
  // modem pins
  input  wire logic        modem_ri_i,
  input  wire logic        modem_cd_i,
  input  wire logic        modem_dsr_i,
  input  wire logic        modem_cts_i,
  input  wire logic        user_rx_i,
  input  wire logic        modem_tx_clk_i,
  input  wire logic        modem_rx_clk_i,
  // transmit and receive control outputs
  output logic             tx_go_o,
  output logic             tx_buf_sel_o,
  output logic      [1:0]  idle_fill_o,
  output logic             tx_irq_o,
  output logic             tx_bit_tick_o,
  output logic             rx_bit_tick_o,
  output logic             dte_timing_o,
  output logic             rx_disable_o,
  output logic      [7:0]  protocol_o
);
  logic [6:0]  pin_s;
  logic [6:0]  pin_prev_q;
  logic [7:0]  mod8;
  logic [7:0]  mod_prev8;
  logic [7:0]  mod_chg;
  logic        en_q, sel_q, idle_q, dsie_q, txie_q, dsc_q, dsec_q, dpri_q;
  logic        en_d, sel_d, idle_d, dsie_d, txie_d, dsc_d, dsec_d, dpri_d;
  logic        csrc_q, rxinv_q, abort_q, csrc_d, rxinv_d, abort_d;
  logic [3:0]  ptr_q, ptr_d, cidx_q, cidx_d;
  logic [15:0] cache_q, cache_d, rdata_q, rdata_d;
  logic [15:0] ind_q [16];
  logic [15:0] ind_d [16];
  logic [7:0]  dscf_q, dscf_d, mrcnt_q, mrcnt_d;
  tcs_pkg::tcs_mr_t mr_q, mr_d;
  logic        ack_q, go_q, go_d, irq_q, irq_d, txt_q, txt_d;
  logic        rxt_q, rxt_d, dte_q, dte_d;
  logic [1:0]  fill_q, fill_d;
  logic        wr_csr, wr_misc, wr_ind, rd_ind, mr, terr_q, terr_d, bitor;
  logic        txc_rise, rxc_edge, err_in;
  tcs_baud_if  bif ();

  // pin synchronisers: rxclk, txclk, dsr, ri, cd, cts, user rx
  tcs_sync #(.W(7)) u_sync (
    .core_clk_i (core_clk_i),
    .d_i        ({modem_rx_clk_i, modem_tx_clk_i, modem_dsr_i, modem_ri_i,
                  modem_cd_i, modem_cts_i, user_rx_i}),
    .q_o        (pin_s)
  );

  tcs_baud u_baud (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .bif        (bif)
  );

  // decode, modem mapping and clock edge detection
  assign wr_csr    = bus_sel_i & bus_wr_i & (bus_addr_i == `TCS_OFS_TXCSR);
  assign wr_misc   = bus_sel_i & bus_wr_i & (bus_addr_i == `TCS_OFS_MISC);
  assign wr_ind    = bus_sel_i & bus_wr_i & (bus_addr_i == `TCS_OFS_IND);
  assign rd_ind    = bus_sel_i & ~bus_wr_i & (bus_addr_i == `TCS_OFS_IND);
  assign mr        = (mr_q == tcs_pkg::TCS_MR_BUSY);
  assign mod8      = {pin_s[4], pin_s[3], pin_s[2], pin_s[1], 1'b0,
                      pin_s[0], 2'b00};
  assign mod_prev8 = {pin_prev_q[4], pin_prev_q[3], pin_prev_q[2],
                      pin_prev_q[1], 1'b0, pin_prev_q[0], 2'b00};
  assign mod_chg   = mod8 ^ mod_prev8;
  assign txc_rise  = pin_s[5] & ~pin_prev_q[5];
  assign rxc_edge  = rxinv_q ? (~pin_s[6] & pin_prev_q[6])  // RQ14
                             : (pin_s[6] & ~pin_prev_q[6]);
  assign err_in    = tx_dma_err_i | tx_underrun_i | tx_len_err_i;
  assign terr_q    = (|ind_q[`TCS_IND_TXERR][7:0]) | abort_q;  // RQ15
  assign bitor     = (ind_q[`TCS_IND_PROTO][5:3] == `TCS_PROTO_B1) |
                     (ind_q[`TCS_IND_PROTO][5:3] == `TCS_PROTO_B2);
  assign bif.rate    = ind_q[`TCS_IND_TXERR][11:8];  // RQ23
  assign bif.src_int = csrc_q;

  // register state next values
  always_comb begin
    en_d = en_q; sel_d = sel_q; idle_d = idle_q; dsie_d = dsie_q;
    txie_d = txie_q; dsc_d = dsc_q; dsec_d = dsec_q; dpri_d = dpri_q;
    csrc_d = csrc_q; rxinv_d = rxinv_q; abort_d = abort_q;
    ptr_d = ptr_q; cidx_d = cidx_q; cache_d = cache_q;
    dscf_d = dscf_q; mr_d = mr_q; mrcnt_d = mrcnt_q;
    ind_d = ind_q;
    // software writes to the transmit control word
    if (wr_csr) begin
      en_d    = bus_wdata_i[`TCS_TX_EN];
      sel_d   = bus_wdata_i[`TCS_TX_SEL];
      idle_d  = bus_wdata_i[`TCS_TX_IDLE];
      dsie_d  = bus_wdata_i[`TCS_TX_DSIE];
      txie_d  = bus_wdata_i[`TCS_TX_TXIE];
      dsec_d  = bus_wdata_i[`TCS_TX_DSEC];
      csrc_d  = bus_wdata_i[`TCS_TX_CSRC];  // RQ13
      rxinv_d = bus_wdata_i[`TCS_TX_RXINV];
      if (!en_q && bus_wdata_i[`TCS_TX_EN]) begin
        ind_d[`TCS_IND_TXERR][7:0] = 8'h00;  // RQ2
        abort_d = 1'b0;
      end
      if (en_q && !bus_wdata_i[`TCS_TX_EN] && tx_active_i) begin
        abort_d = 1'b1;  // RQ3
        if (sel_q) begin
          dsec_d = 1'b1;
        end else begin
          dpri_d = 1'b1;
        end
      end
    end
    // indirect data port write, then pointer advance
    if (wr_ind) begin
      if (ptr_q == `TCS_IND_MODEM) begin
        ind_d[ptr_q][15:8] = bus_wdata_i[15:8];
      end else begin
        ind_d[ptr_q] = bus_wdata_i;
      end
      if (ptr_q == `TCS_IND_PCNT) begin
        dpri_d = 1'b0;  // RQ12
      end
      if (ptr_q == `TCS_IND_SCNT) begin
        dsec_d = 1'b0;  // RQ11
      end
      ptr_d = ptr_q + 4'h1;  // RQ17
    end
    // pointer write and master reset start
    if (wr_misc) begin
      ptr_d = bus_wdata_i[3:0];
      if (bus_wdata_i[`TCS_MISC_MR] && !mr) begin
        mr_d    = tcs_pkg::TCS_MR_BUSY;  // RQ20
        mrcnt_d = `TCS_MR_CYCLES;
      end
    end
    // reads of the cached indirect register clear flags
    if (rd_ind && cidx_q == `TCS_IND_TXERR) begin
      ind_d[`TCS_IND_TXERR][7:0] = 8'h00;  // RQ15
      abort_d = 1'b0;
    end
    if (rd_ind && cidx_q == `TCS_IND_MODEM) begin
      dsc_d  = 1'b0;  // RQ10
      dscf_d = 8'h00;  // RQ22
    end
    // hardware events win over clears
    if (tx_dma_err_i) ind_d[`TCS_IND_TXERR][`TCS_ERR_DMA] = 1'b1;
    if (tx_underrun_i) ind_d[`TCS_IND_TXERR][`TCS_ERR_UNDR] = 1'b1;
    if (tx_len_err_i) ind_d[`TCS_IND_TXERR][`TCS_ERR_LEN] = 1'b1;
    if (err_in) en_d = 1'b0;  // RQ4
    if (tx_msg_done_i && sel_q) dsec_d = 1'b1;  // RQ11
    if (tx_msg_done_i && !sel_q) dpri_d = 1'b1;  // RQ12
    if (tx_dma_end_i) sel_d = ~sel_d;  // RQ5
    dscf_d = dscf_d | mod_chg;  // RQ22
    if (|mod_chg) dsc_d = 1'b1;  // RQ10
    ind_d[`TCS_IND_MODEM][7:0] = mod8;
    // master reset in progress; pointer and counts untouched
    if (mr) begin
      en_d = 1'b0; sel_d = 1'b0; idle_d = 1'b0; dsie_d = 1'b0;  // RQ21
      txie_d = 1'b0; csrc_d = 1'b0; rxinv_d = 1'b0; abort_d = 1'b0;
      dsec_d = `TCS_RST_DONE; dpri_d = `TCS_RST_DONE;
      dsc_d = 1'b0; dscf_d = 8'h00;
      ind_d[`TCS_IND_TXERR] = 16'h0000;
      mrcnt_d = mrcnt_q - 8'h01;
      if (mrcnt_q == 8'h01) mr_d = tcs_pkg::TCS_MR_IDLE;  // RQ20
    end
    // latch indirect data whenever the pointer is written or moves
    if (wr_misc || wr_ind || ptr_d != ptr_q) begin
      cache_d = ind_d[ptr_d];  // RQ18
      cidx_d  = ptr_d;
    end
  end

  // read data and pin-facing outputs
  always_comb begin
    unique case (bus_addr_i)
      `TCS_OFS_TXCSR: rdata_d = {dpri_q, terr_q, 4'h0, rxinv_q, csrc_q,
                                 dsec_q, dsc_q, txie_q, dsie_q, idle_q,
                                 sel_q, 1'b0, en_q};
      `TCS_OFS_MISC:  rdata_d = {8'h00, mr_q == tcs_pkg::TCS_MR_BUSY,
                                 3'h0, ptr_q};  // RQ16
      `TCS_OFS_IND:   rdata_d = cache_q;
      `TCS_OFS_DSCF:  rdata_d = {8'h00, dscf_q};
      default:        rdata_d = 16'h0000;
    endcase
    if (!bus_sel_i || bus_wr_i) rdata_d = 16'h0000;
    terr_d = (|ind_d[`TCS_IND_TXERR][7:0]) | abort_d;
    // a master reset starting this cycle blocks transmit at once
    go_d   = en_d & ~(sel_d ? dsec_d : dpri_d) &
             (mr_d != tcs_pkg::TCS_MR_BUSY);  // RQ1
    irq_d  = (dsie_q & dsc_q) |  // RQ8
             (txie_q & ((dpri_d & ~dpri_q) | (dsec_d & ~dsec_q) |
                        (terr_d & ~terr_q)));  // RQ9
    txt_d  = csrc_q ? bif.tick : txc_rise;  // RQ13
    rxt_d  = int_loop_i ? txt_d : rxc_edge;  // RQ14
    dte_d  = csrc_q ? bif.clk_out : 1'b1;  // RQ13
    if (!en_q || mr) begin
      fill_d = tcs_pkg::TCS_FILL_MARK;  // RQ7
    end else if (bitor) begin
      fill_d = idle_q ? tcs_pkg::TCS_FILL_FLAG : tcs_pkg::TCS_FILL_MARK;
    end else begin
      fill_d = idle_q ? tcs_pkg::TCS_FILL_MARK : tcs_pkg::TCS_FILL_SYNC;
    end  // RQ6
  end

  // registers; pointer, cache and buffer registers have no reset
  always_ff @(posedge core_clk_i) begin
    ptr_q      <= ptr_d;  // RQ19
    cidx_q     <= cidx_d;
    cache_q    <= cache_d;
    ind_q      <= ind_d;
    pin_prev_q <= pin_s;
    if (reset_i) begin
      en_q <= 1'b0; sel_q <= 1'b0; idle_q <= 1'b0; dsie_q <= 1'b0;
      txie_q <= 1'b0; csrc_q <= 1'b0; rxinv_q <= 1'b0; abort_q <= 1'b0;
      dsec_q <= `TCS_RST_DONE; dpri_q <= `TCS_RST_DONE;
      dsc_q <= 1'b0; dscf_q <= 8'h00; mrcnt_q <= 8'h00;
      mr_q <= tcs_pkg::TCS_MR_IDLE;
      ind_q[`TCS_IND_TXERR] <= 16'h0000;
      ind_q[`TCS_IND_MODEM] <= 16'h0000;
      rdata_q <= 16'h0000; ack_q <= 1'b0; go_q <= 1'b0; irq_q <= 1'b0;
      txt_q <= 1'b0; rxt_q <= 1'b0; dte_q <= 1'b1;
      fill_q <= tcs_pkg::TCS_FILL_MARK;
    end else begin
      en_q <= en_d; sel_q <= sel_d; idle_q <= idle_d; dsie_q <= dsie_d;
      txie_q <= txie_d; csrc_q <= csrc_d; rxinv_q <= rxinv_d;
      abort_q <= abort_d; dsec_q <= dsec_d; dpri_q <= dpri_d;
      dsc_q <= dsc_d; dscf_q <= dscf_d; mrcnt_q <= mrcnt_d; mr_q <= mr_d;
      rdata_q <= rdata_d; ack_q <= bus_sel_i; go_q <= go_d;
      irq_q <= irq_d; txt_q <= txt_d; rxt_q <= rxt_d; dte_q <= dte_d;
      fill_q <= fill_d;
    end
  end

  assign bus_rdata_o   = rdata_q;
  assign bus_ack_o     = ack_q;
  assign tx_go_o       = go_q;
  assign tx_buf_sel_o  = sel_q;
  assign idle_fill_o   = fill_q;
  assign tx_irq_o      = irq_q;
  assign tx_bit_tick_o = txt_q;
  assign rx_bit_tick_o = rxt_q;
  assign dte_timing_o  = dte_q;
  assign rx_disable_o  = mr;
  assign protocol_o    = ind_q[`TCS_IND_PROTO][7:0];

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence en_rise_s;
    wr_csr && !en_q && bus_wdata_i[`TCS_TX_EN] && !err_in && !mr;
  endsequence
  en_rise_clr_a: assert property (en_rise_s |=>  // RQ2
    ind_q[`TCS_IND_TXERR][7:0] == 8'h00)
    else $error("enable rise left error flags");
  abort_flag_a: assert property (wr_csr && en_q && tx_active_i && !mr &&  // RQ3
    !bus_wdata_i[`TCS_TX_EN] |=>
    terr_q && ($past(sel_q) ? dsec_q : dpri_q))
    else $error("abort did not set error and done");
  err_drop_en_a: assert property (err_in |=> !en_q)  // RQ4
    else $error("error did not clear enable");
  sel_toggle_a: assert property (tx_dma_end_i && !wr_csr && !mr |=>  // RQ5
    sel_q != $past(sel_q))
    else $error("select did not toggle");
  ds_irq_a: assert property (dsie_q && dsc_q |=> tx_irq_o)  // RQ8
    else $error("data set interrupt missing");
  ptr_inc_a: assert property (wr_ind |=> ptr_q == $past(ptr_q) + 4'h1)  // RQ17
    else $error("pointer did not advance");
  cache_fill_a: assert property (wr_misc && !mr |=>  // RQ18
    cidx_q == $past(bus_wdata_i[3:0]))
    else $error("cache not reloaded");
  // master reset stands for two runs of eight cycles, then ends
  sequence mr_half_s;
    mr [*8];
  endsequence
  mr_len_a: assert property ($rose(mr) |->  // RQ20
    mr_half_s ##1 mr_half_s ##1 !mr)
    else $error("master reset length wrong");
  go_gate_a: assert property (tx_go_o |-> en_q && !mr)  // RQ1
    else $error("transmit allowed while disabled");
endmodule

// ---- rtl/tcs_map.svh ----
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
// register byte offsets
`define TCS_OFS_TXCSR 4'h4
`define TCS_OFS_MISC  4'h8
`define TCS_OFS_IND   4'hA
`define TCS_OFS_DSCF  4'hC
// transmit control/status word fields
`define TCS_TX_EN     0
`define TCS_TX_SEL    2
`define TCS_TX_IDLE   3
`define TCS_TX_DSIE   4
`define TCS_TX_TXIE   5
`define TCS_TX_DSC    6
`define TCS_TX_DSEC   7
`define TCS_TX_CSRC   8
`define TCS_TX_RXINV  9
`define TCS_TX_TERR   14
`define TCS_TX_DPRI   15
// misc register fields
`define TCS_MISC_MR   7
// indirect register indices
`define TCS_IND_PROTO 4'h0
`define TCS_IND_TXERR 4'h2
`define TCS_IND_MODEM 4'h4
`define TCS_IND_PCNT  4'hB
`define TCS_IND_SCNT  4'hD
// transmit error flag bits in indirect 2
`define TCS_ERR_DMA   0
`define TCS_ERR_UNDR  1
`define TCS_ERR_LEN   2
// protocol codes that are bit oriented
`define TCS_PROTO_B1  3'h1
`define TCS_PROTO_B2  3'h2
// reset values and timing counts
`define TCS_RST_DONE  1'b1
`define TCS_MR_CYCLES 8'h10
`define TCS_BAUD_UNIT 12'h010
`endif

// ---- rtl/tcs_pkg.sv ----
package tcs_pkg;
  typedef enum logic [0:0] {
    TCS_MR_IDLE = 1'b0,
    TCS_MR_BUSY = 1'b1
  } tcs_mr_t;
  typedef enum logic [1:0] {
    TCS_FILL_MARK = 2'b00,
    TCS_FILL_SYNC = 2'b01,
    TCS_FILL_FLAG = 2'b10
  } tcs_fill_t;
endpackage

// ---- rtl/tcs_baud_if.sv ----
`timescale 1ns/1ps
// baud generator control and its outputs
interface tcs_baud_if;
  logic [3:0] rate;
  logic       src_int;
  logic       tick;
  logic       clk_out;
  modport gen  (input rate, input src_int, output tick, output clk_out);
  modport user (output rate, output src_int, input tick, input clk_out);
endinterface

// ---- rtl/tcs_sync.sv ----
`timescale 1ns/1ps
module tcs_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         core_clk_i,
  // asynchronous levels in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // two stage synchroniser, first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
  end
  assign q_o = s2_q;
endmodule

// ---- rtl/tcs_baud.sv ----
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_baud (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // control and outputs
  tcs_baud_if.gen   bif
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        clk_q;
  logic        clk_d;
  logic        tick_q;
  logic        tick_d;
  logic [11:0] lim;

  // divide by (rate+1) units per half period; idle high when unused
  always_comb begin
    lim    = 12'(({8'h00, bif.rate} + 12'h001) * `TCS_BAUD_UNIT);
    cnt_d  = cnt_q + 12'h001;
    clk_d  = clk_q;
    tick_d = 1'b0;
    if (!bif.src_int) begin
      cnt_d = 12'h000;
      clk_d = 1'b1;
    end else if (cnt_q >= lim - 12'h001) begin
      cnt_d  = 12'h000;
      clk_d  = ~clk_q;
      tick_d = ~clk_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q  <= 12'h000;
      clk_q  <= 1'b1;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      clk_q  <= clk_d;
      tick_q <= tick_d;
    end
  end
  assign bif.tick    = tick_q;
  assign bif.clk_out = clk_q;
endmodule

// ---- bench/tcs_host.sv ----
`timescale 1ns/1ps
// host bus master model: one-cycle strobe per whole-word access
module tcs_host (
  // clock
  input  wire logic        core_clk_i,
  // register port
  output logic             bus_sel_o,
  output logic             bus_wr_o,
  output logic [3:0]       bus_addr_o,
  output logic [15:0]      bus_wdata_o,
  input  wire logic [15:0] bus_rdata_i,
  input  wire logic        bus_ack_i
);
  // idle bus at time zero
  initial begin
    bus_sel_o   = 1'b0;
    bus_wr_o    = 1'b0;
    bus_addr_o  = 4'h0;
    bus_wdata_o = 16'h0000;
  end
  // word access, answer taken once the acknowledge is seen
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(negedge core_clk_i);
    bus_sel_o   = 1'b1;
    bus_wr_o    = w;
    bus_addr_o  = a;
    bus_wdata_o = d;
    @(negedge core_clk_i);
    // released lines carry the inverse so stale values cannot pass
    bus_sel_o   = 1'b0;
    bus_addr_o  = ~a;
    bus_wdata_o = ~d;
    while (bus_ack_i !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    q = bus_rdata_i;
  endtask
endmodule

// ---- bench/tb_tcs_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_tcs_top;
  typedef struct packed { logic [15:0] v; logic [15:0] m; } tcs_exp_t;
  logic        clk, rst, sel, wr, ack, act, lp, txc, rxc, rd_q;
  logic        go, bsel, irq, ttk, rtk, dte, rxd;
  logic [3:0]  addr;
  logic [15:0] wd, rdat;
  logic [4:0]  ev, mdm;
  logic [1:0]  fill;
  logic [7:0]  proto;
  logic [15:0] v [3];
  logic [15:0] mbit [5];
  logic [1:0]  fexp [4];
  logic        dprev;
  logic [15:0] acc;
  tcs_exp_t    expq [$];
  int          fails, n_tests, irq_n, i, p, tog, base, tt, rt;
  // clocks: core at 4 ns, modem clocks at 125 ns, unrelated in phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    txc = 1'b0;
    #31 forever #62.5 txc = ~txc;
  end
  initial begin
    rxc = 1'b0;
    #77 forever #62.5 rxc = ~rxc;
  end
  tcs_top dut (
    .core_clk_i(clk), .reset_i(rst), .bus_sel_i(sel), .bus_wr_i(wr),
    .bus_addr_i(addr), .bus_wdata_i(wd), .bus_rdata_o(rdat),
    .bus_ack_o(ack), .tx_active_i(act), .tx_msg_done_i(ev[0]),
    .tx_dma_end_i(ev[1]), .tx_dma_err_i(ev[2]), .tx_underrun_i(ev[3]),
    .tx_len_err_i(ev[4]), .int_loop_i(lp), .modem_dsr_i(mdm[0]),
    .modem_ri_i(mdm[1]), .modem_cd_i(mdm[2]), .modem_cts_i(mdm[3]),
    .user_rx_i(mdm[4]), .modem_tx_clk_i(txc), .modem_rx_clk_i(rxc),
    .tx_go_o(go), .tx_buf_sel_o(bsel), .idle_fill_o(fill),
    .tx_irq_o(irq), .tx_bit_tick_o(ttk), .rx_bit_tick_o(rtk),
    .dte_timing_o(dte), .rx_disable_o(rxd), .protocol_o(proto));
  tcs_host host (
    .core_clk_i(clk), .bus_sel_o(sel), .bus_wr_o(wr), .bus_addr_o(addr),
    .bus_wdata_o(wd), .bus_rdata_i(rdat), .bus_ack_i(ack));
  // read answers are matched against the oldest noted expectation
  always @(posedge clk) rd_q <= sel && !wr;
  always @(negedge clk) begin
    if (ack === 1'b1 && rd_q && expq.size() > 0) begin
      `CHK(rdat & expq[0].m, expq[0].v & expq[0].m)
      void'(expq.pop_front());
    end
  end
  // interrupt request cycles seen
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e,
                        input logic [15:0] m);
    logic [15:0] q;
    expq.push_back({e, m});
    host.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev[k] = 1'b0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #60000;
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end
  // main sequence
  initial begin
    rst = 1'b1; act = 1'b0; lp = 1'b0; ev = 5'h00; mdm = 5'h00;
    fails = 0; n_tests = 0; irq_n = 0;
    mbit = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0004};
    fexp = '{tcs_pkg::TCS_FILL_SYNC, tcs_pkg::TCS_FILL_MARK,
             tcs_pkg::TCS_FILL_MARK, tcs_pkg::TCS_FILL_FLAG};
    void'($urandom(32'hef9d3c88));
    for (i = 0; i < 3; i++) v[i] = 16'($urandom()) & 16'h3FFF;
    cyc(3);
    rst = 1'b0;
    rd_reg(4'h4, 16'h8080, 16'hFFFF);
    rd_reg(4'hC, 16'h0000, 16'hFFFF);
    wr_reg(4'h6, 16'hFFFF);
    rd_reg(4'h6, 16'h0000, 16'hFFFF);
    `CHK(dte, 1'b1)
    $display("reset test done");
    wr_reg(4'h8, 16'h000B);
    for (i = 0; i < 3; i++) wr_reg(4'hA, v[i]);
    rd_reg(4'h4, 16'h0000, 16'h8080);
    rd_reg(4'h8, 16'h000E, 16'h008F);
    for (i = 0; i < 3; i++) begin
      wr_reg(4'h8, 16'h000B + 16'(i));
      rd_reg(4'hA, v[i], 16'h3FFF);
    end
    $display("indirect test done");
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'hA, 16'h0000);
    wr_reg(4'h4, 16'h0100);
    tog = 0;
    tt = 0;
    rt = 0;
    dprev = dte;
    repeat (80) begin
      @(negedge clk);
      if (dte !== dprev) tog++;
      if (ttk === 1'b1) tt++;
      if (rtk === 1'b1) rt++;
      dprev = dte;
    end
    `CHK(tog >= 2, 1'b1)
    `CHK(tt >= 2, 1'b1)
    `CHK(rt >= 2, 1'b1)
    // internal loop: receive ticks must follow the transmit ticks
    lp = 1'b1;
    tt = 0;
    rt = 0;
    repeat (40) begin
      @(negedge clk);
      if (ttk === 1'b1) tt++;
      if (rtk !== ttk) rt++;
    end
    lp = 1'b0;
    `CHK(tt >= 1, 1'b1)
    `CHK(rt, 0)
    wr_reg(4'h4, 16'h0000);
    cyc(2);
    `CHK(dte, 1'b1)
    $display("clock source test done");
    for (i = 2; i < 5; i++) begin
      wr_reg(4'h4, 16'h0021);
      cyc(2);
      `CHK(go, 1'b1)
      base = irq_n;
      pulse(i);
      cyc(2);
      `CHK(go, 1'b0)
      `CHK(irq_n - base, 1)
      rd_reg(4'h4, 16'h4020, 16'h4021);
      wr_reg(4'h8, 16'h0002);
      rd_reg(4'hA, 16'h0001 << (i - 2), 16'h00FF);
      rd_reg(4'h4, 16'h0020, 16'h4021);
    end
    pulse(2);
    wr_reg(4'h4, 16'h0021);
    rd_reg(4'h4, 16'h0021, 16'h4021);
    wr_reg(4'h8, 16'h0002);
    rd_reg(4'hA, 16'h0000, 16'h00FF);
    $display("error test done");
    base = irq_n;
    act = 1'b1;
    wr_reg(4'h4, 16'h0020);
    act = 1'b0;
    cyc(2);
    rd_reg(4'h4, 16'hC020, 16'hC0A1);
    `CHK(irq_n != base, 1'b1)
    wr_reg(4'h8, 16'h0002);
    rd_reg(4'hA, 16'h0000, 16'h00FF);
    pulse(1);
    cyc(1);
    `CHK(bsel, 1'b1)
    rd_reg(4'h4, 16'h8004, 16'hC084);
    pulse(0);
    rd_reg(4'h4, 16'h8084, 16'h8084);
    pulse(1);
    cyc(1);
    `CHK(bsel, 1'b0)
    $display("abort and buffer test done");
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 2; i++) begin
        wr_reg(4'h8, 16'h0000);
        wr_reg(4'hA, 16'(p) << 3);
        wr_reg(4'h4, 16'h0001 | (16'(i) << 3));
        cyc(2);
        `CHK(fill, fexp[p * 2 + i])
      end
    end
    wr_reg(4'h4, 16'h0000);
    cyc(2);
    `CHK(fill, tcs_pkg::TCS_FILL_MARK)
    $display("idle fill test done");
    wr_reg(4'h4, 16'h0010);
    acc = 16'h0000;
    for (i = 0; i < 5; i++) begin
      mdm[i] = ~mdm[i];
      acc = acc | mbit[i];
      cyc(8);
      rd_reg(4'hC, mbit[i], 16'hFFFF);
      rd_reg(4'h4, 16'h0040, 16'h0040);
      `CHK(irq, 1'b1)
      wr_reg(4'h8, 16'h0004);
      rd_reg(4'hA, acc, 16'hFFFF);
      rd_reg(4'hC, 16'h0000, 16'hFFFF);
      rd_reg(4'h4, 16'h0000, 16'h0040);
    end
    $display("modem test done");
    wr_reg(4'h8, 16'h0080);
    rd_reg(4'h8, 16'h0080, 16'h0080);
    `CHK(rxd, 1'b1)
    wr_reg(4'h8, 16'h0080);
    cyc(11);
    rd_reg(4'h8, 16'h0000, 16'h0080);
    `CHK(rxd, 1'b0)
    rd_reg(4'h4, 16'h8080, 16'hFFFF);
    `CHK(proto, 8'h08)
    wr_reg(4'h8, 16'h000B);
    rd_reg(4'hA, v[0], 16'h3FFF);
    $display("master reset test done");
    cyc(2);
    print_verdict();
  end
endmodule
